/* File: rtl/spisf_status_flags.v */
// Status and event-flag logic of the serial controller, slave and master busy conditions.
`timescale 1ns/1ps
`include "spisf_defines.vh"

module spisf_status_flags (
  // Clock and reset.
  input  wire                         core_clk,
  input  wire                         nrst,
  // Configuration.
  input  wire                         ctlEnable,
  input  wire                         slaveMode,
  input  wire                         chip_select_polarity,
  input  wire [`SPISF_WIDTH_BITS-1:0] data_width_setting,
  input  wire                         receive_only_select,
  // Transfer engine status, same clock.
  input  wire                         tx_fifo_empty,
  input  wire                         txShiftBusy,
  input  wire                         txUnderflow,
  input  wire                         masterXferActive,
  input  wire                         unitDone,
  // Serial pins, asynchronous.
  input  wire                         serialClkPin,
  input  wire                         chipSelectPin,
  // Write-one-to-clear strobes.
  input  wire                         clrUnderrun,
  input  wire                         clrBitcountError,
  input  wire                         clrDeassert,
  input  wire                         clrAssert,
  input  wire                         clrTransferDone,
  // Status outputs.
  output reg                          slave_tx_underrun_flag,
  output reg                          slave_bitcount_error_flag,
  output reg                          chip_select_level,
  output reg                          chip_select_deassert_flag,
  output reg                          chip_select_assert_flag,
  output reg                          transfer_done_flag,
  output reg                          busy
);

  reg                        sclkMeta_r;
  reg                        sclkSync_r;
  reg                        sclkPrev_r;
  reg                        csMeta_r;
  reg                        csSync_r;
  reg                        csActPrev_r;
  reg                        underflowSeen_r;
  reg [`SPISF_CNT_BITS-1:0]  bitCount_r;
  reg                        sclkSeen_r;
  reg                        slaveClkBusy_r;

  wire csActive;
  wire csRise;
  wire csFall;
  wire sclkEdge;
  wire widthMatch;
  wire busyNxt;
  wire busyFifo;
  wire busyMasterXfer;
  wire busyRxOnly;
  wire busySlaveClk;
  wire busySlaveData;
  wire underrunSet;
  wire bitErrorSet;
  wire deassertSet;
  wire assertSet;

  reg [`SPISF_CNT_BITS-1:0]  bitCount_nxt;
  reg                        sclkSeen_nxt;
  reg                        underflowSeen_nxt;
  reg                        slaveClkBusy_nxt;

  // Data width setting converted to a bit count; zero stands for a full word.
  function [`SPISF_CNT_BITS-1:0] unitBits;
    input [`SPISF_WIDTH_BITS-1:0] w;
    begin
      if (w == `SPISF_WIDTH_ZERO) begin
        unitBits = `SPISF_WIDTH_FULL;
      end else begin
        unitBits = {1'b0, w};
      end
    end
  endfunction

  // Sticky flag update: a set in the same cycle as a write-one clear wins.
  function flagNext;
    input cur;
    input setEv;
    input clrEv;
    begin
      if (setEv) begin
        flagNext = 1'b1;
      end else if (clrEv) begin
        flagNext = 1'b0;
      end else begin
        flagNext = cur;
      end
    end
  endfunction

  // Active-low polarity treats a high line as deselected.
  assign csActive = (chip_select_polarity == `SPISF_POL_LOW) ? ~csSync_r : csSync_r;
  assign csRise   = csActive & ~csActPrev_r;
  assign csFall   = ~csActive & csActPrev_r;
  assign sclkEdge = sclkSync_r & ~sclkPrev_r;
  assign widthMatch = (bitCount_r == unitBits(data_width_setting));

  // Select events and the checks made at deselect exist only in slave mode.
  assign underrunSet = slaveMode & csFall & (underflowSeen_r | txUnderflow);
  assign bitErrorSet = slaveMode & csFall & (~widthMatch | ~sclkSeen_r);
  assign deassertSet = slaveMode & csFall;
  assign assertSet   = slaveMode & csRise;

  // Busy conditions; with none of them true the block reports idle.
  assign busyFifo       = ~tx_fifo_empty;
  assign busyMasterXfer = ~slaveMode & masterXferActive;
  assign busyRxOnly     = ~slaveMode & receive_only_select;
  assign busySlaveClk   = slaveMode & slaveClkBusy_r;
  assign busySlaveData  = slaveMode & txShiftBusy;
  assign busyNxt = ctlEnable & (busyFifo | busyMasterXfer | busyRxOnly
                   | busySlaveClk | busySlaveData);

  // Bit counter restarts at each selection and wraps after each full unit.
  always @* begin
    bitCount_nxt = bitCount_r;
    sclkSeen_nxt = sclkSeen_r;
    if (csRise) begin
      bitCount_nxt = `SPISF_CNT_ZERO;
      sclkSeen_nxt = 1'b0;
    end else if (csActive && sclkEdge) begin
      sclkSeen_nxt = 1'b1;
      if (widthMatch) begin
        bitCount_nxt = `SPISF_CNT_ONE;
      end else begin
        bitCount_nxt = bitCount_r + `SPISF_CNT_ONE;
      end
    end
  end

  // An underflow is remembered until the slave is next deselected.
  always @* begin
    underflowSeen_nxt = underflowSeen_r;
    if (!slaveMode || csFall) begin
      underflowSeen_nxt = 1'b0;
    end else if (txUnderflow) begin
      underflowSeen_nxt = 1'b1;
    end
  end

  // Clock activity while selected counts as busy until deselect.
  always @* begin
    if (csActive && sclkEdge) begin
      slaveClkBusy_nxt = 1'b1;
    end else begin
      slaveClkBusy_nxt = csActive & slaveClkBusy_r;
    end
  end

  // Two flip-flops bring the serial clock pin into the core clock domain.
  always @(posedge core_clk) begin
    if (!nrst) begin
      sclkMeta_r <= `SPISF_IDLE_SCLK;
      sclkSync_r <= `SPISF_IDLE_SCLK;
    end else begin
      sclkMeta_r <= serialClkPin;
      sclkSync_r <= sclkMeta_r;
    end
  end

  // Previous synchronised clock level, for rising-edge detection.
  always @(posedge core_clk) begin
    if (!nrst) begin
      sclkPrev_r <= `SPISF_IDLE_SCLK;
    end else begin
      sclkPrev_r <= sclkSync_r;
    end
  end

  // Chip-select is synchronised alike; the edge history follows it in reset.
  always @(posedge core_clk) begin
    if (!nrst) begin
      csMeta_r    <= `SPISF_IDLE_CS;
      csSync_r    <= `SPISF_IDLE_CS;
      csActPrev_r <= csActive;
    end else begin
      csMeta_r    <= chipSelectPin;
      csSync_r    <= csMeta_r;
      csActPrev_r <= csActive;
    end
  end

  // Line level as seen after synchronisation.
  always @(posedge core_clk) begin
    if (!nrst) begin
      chip_select_level <= `SPISF_IDLE_CS;
    end else begin
      chip_select_level <= csSync_r;
    end
  end

  // Bits clocked in the current unit and whether any clock came at all.
  always @(posedge core_clk) begin
    if (!nrst) begin
      bitCount_r <= `SPISF_CNT_ZERO;
      sclkSeen_r <= 1'b0;
    end else begin
      bitCount_r <= bitCount_nxt;
      sclkSeen_r <= sclkSeen_nxt;
    end
  end

  // Underflow memory for the current selection.
  always @(posedge core_clk) begin
    if (!nrst) begin
      underflowSeen_r <= 1'b0;
    end else begin
      underflowSeen_r <= underflowSeen_nxt;
    end
  end

  // Slave clock activity memory.
  always @(posedge core_clk) begin
    if (!nrst) begin
      slaveClkBusy_r <= 1'b0;
    end else begin
      slaveClkBusy_r <= slaveClkBusy_nxt;
    end
  end

  // Registered busy indication.
  always @(posedge core_clk) begin
    if (!nrst) begin
      busy <= 1'b0;
    end else begin
      busy <= busyNxt;
    end
  end

  // Underrun flag.
  always @(posedge core_clk) begin
    if (!nrst) begin
      slave_tx_underrun_flag <= 1'b0;
    end else begin
      slave_tx_underrun_flag <= flagNext(slave_tx_underrun_flag, underrunSet, clrUnderrun);
    end
  end

  // Bit-count error flag.
  always @(posedge core_clk) begin
    if (!nrst) begin
      slave_bitcount_error_flag <= 1'b0;
    end else begin
      slave_bitcount_error_flag <= flagNext(slave_bitcount_error_flag, bitErrorSet,
                                            clrBitcountError);
    end
  end

  // Deselect event flag.
  always @(posedge core_clk) begin
    if (!nrst) begin
      chip_select_deassert_flag <= 1'b0;
    end else begin
      chip_select_deassert_flag <= flagNext(chip_select_deassert_flag, deassertSet, clrDeassert);
    end
  end

  // Select event flag.
  always @(posedge core_clk) begin
    if (!nrst) begin
      chip_select_assert_flag <= 1'b0;
    end else begin
      chip_select_assert_flag <= flagNext(chip_select_assert_flag, assertSet, clrAssert);
    end
  end

  // Unit transfer done flag.
  always @(posedge core_clk) begin
    if (!nrst) begin
      transfer_done_flag <= 1'b0;
    end else begin
      transfer_done_flag <= flagNext(transfer_done_flag, unitDone, clrTransferDone);
    end
  end

endmodule // spisf_status_flags

/* File: inc/spisf_defines.vh */
// Constants for the serial status and event-flag block.
`ifndef SPISF_DEFINES_VH
`define SPISF_DEFINES_VH
`define SPISF_WIDTH_BITS   5
`define SPISF_WIDTH_FULL   6'h20
`define SPISF_WIDTH_ZERO   5'h00
`define SPISF_CNT_BITS     6
`define SPISF_CNT_ZERO     6'h00
`define SPISF_CNT_ONE      6'h01
`define SPISF_POL_LOW      1'b0
`define SPISF_IDLE_SCLK    1'b0
`define SPISF_IDLE_CS      1'b1
`endif

/* File: tb/spisf_checker.sv */
// Assertions on the ports of the serial status and event-flag block.
`timescale 1ns/1ps
module spisf_checker (input wire core_clk, nrst, ctlEnable, slaveMode, receive_only_select,
  tx_fifo_empty, txShiftBusy, masterXferActive, unitDone, clrTransferDone, busy,
  transfer_done_flag, chip_select_assert_flag, chip_select_deassert_flag);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence masterTwo; !slaveMode ##1 !slaveMode; endsequence
  done_set_a: assert property (unitDone |=> transfer_done_flag)
    else $error("done flag not set");
  done_keep_a: assert property (transfer_done_flag && !clrTransferDone
    |=> transfer_done_flag) else $error("done flag lost");
  done_clear_a: assert property (clrTransferDone && !unitDone
    |=> !transfer_done_flag) else $error("done flag not cleared");
  busy_fifo_a: assert property (ctlEnable && !tx_fifo_empty |=> busy)
    else $error("busy missing with data");
  busy_off_a: assert property (!ctlEnable |=> !busy) else $error("busy while off");
  busy_rxo_a: assert property (ctlEnable && !slaveMode && receive_only_select
    |=> busy) else $error("busy missing receive-only");
  busy_xfer_a: assert property (ctlEnable && !slaveMode && masterXferActive
    |=> busy) else $error("busy missing in transfer");
  busy_txbuf_a: assert property (ctlEnable && slaveMode && txShiftBusy
    |=> busy) else $error("busy missing slave data");
  no_event_a: assert property (masterTwo |-> !$rose(chip_select_assert_flag)
    && !$rose(chip_select_deassert_flag)) else $error("select event in master");
endmodule // spisf_checker
bind spisf_status_flags spisf_checker spisf_checker_inst (.*);

/* File: tb/spisf_serial_master.sv */
// Behavioural serial bus master driving chip-select and serial clock.
`timescale 1ns/1ps
module spisf_serial_master (output logic csPin = 1'b1, output logic sclkPin = 1'b0);
  // The serial clock stands still outside frames; select is active low.
  task automatic frame(input int n);
    csPin = 1'b0;
    #300;
    repeat (n) begin
      sclkPin = 1'b1;
      #100;
      sclkPin = 1'b0;
      #100;
    end
    #300;
    csPin = 1'b1;
    #600;
  endtask
endmodule // spisf_serial_master

/* File: tb/tb_top.sv */
// Self-checking bench for the serial status and event-flag block.
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 0, nrst = 0, ctlEnable = 0, slaveMode = 0, receive_only_select = 0;
  logic tx_fifo_empty = 1, txShiftBusy = 0, txUnderflow = 0, masterXferActive = 0, unitDone = 0;
  logic clrUnderrun = 0, clrBitcountError = 0, clrDeassert = 0, clrAssert = 0, clrTransferDone = 0;
  logic [4:0] data_width_setting = 5'h08;
  logic [31:0] rnd = 32'heceae267;
  wire serialClkPin, chipSelectPin, slave_tx_underrun_flag, slave_bitcount_error_flag;
  wire chip_select_level, chip_select_deassert_flag, chip_select_assert_flag;
  wire transfer_done_flag, busy;
  int n_mismatch = 0, checks = 0, doneE = 0, wsT[5] = '{8, 8, 8, 0, 5}, nT[5] = '{8, 7, 0, 32, 6};
  spisf_serial_master spisf_serial_master_inst (.csPin(chipSelectPin), .sclkPin(serialClkPin));
  spisf_status_flags spisf_status_flags_inst (.*, .chip_select_polarity(1'b0));
  initial forever #12.5 core_clk = ~core_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("mismatches=%0d checks=%0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic clear_all(input logic v);
    @(negedge core_clk);
    {clrUnderrun, clrBitcountError, clrDeassert, clrAssert, clrTransferDone} = {5{v}};
  endtask
  initial begin
    repeat (3) @(negedge core_clk);
    nrst = 1;
    repeat (300) begin
      @(negedge core_clk);
      rnd = lfsr(rnd);
      {ctlEnable, receive_only_select, tx_fifo_empty, masterXferActive, unitDone} = rnd[4:0];
      clrTransferDone = rnd[5];
      doneE = unitDone ? 1 : clrTransferDone ? 0 : doneE;
      @(negedge core_clk);
      chk(busy, ctlEnable && (!tx_fifo_empty || masterXferActive || receive_only_select));
      chk(transfer_done_flag, doneE[0]);
    end
    {ctlEnable, receive_only_select, tx_fifo_empty, masterXferActive, unitDone} = 5'h04;
    spisf_serial_master_inst.frame(8);
    chk(chip_select_assert_flag | chip_select_deassert_flag, 1'b0);
    {ctlEnable, slaveMode, txShiftBusy} = 3'h7;
    repeat (2) @(negedge core_clk);
    chk(busy, 1'b1);
    txShiftBusy = 0;
    for (int i = 0; i < 5; i++) begin
      data_width_setting = 5'(wsT[i]);
      fork
        spisf_serial_master_inst.frame(nT[i]);
        begin
          repeat (20) @(negedge core_clk);
          chk(chip_select_level, 1'b0);
          chk(chip_select_assert_flag, 1'b1);
          chk(busy, nT[i] > 0);
          txUnderflow = (i == 1);
          repeat (4) @(negedge core_clk);
          txUnderflow = 1'b0;
        end
      join
      txUnderflow = 0;
      chk(slave_bitcount_error_flag, nT[i] != (wsT[i] == 0 ? 32 : wsT[i]));
      chk(slave_tx_underrun_flag, i == 1);
      chk(chip_select_deassert_flag & chip_select_level & !busy, 1'b1);
      clear_all(1'b1);
      clear_all(1'b0);
      @(negedge core_clk);
      chk(slave_bitcount_error_flag | slave_tx_underrun_flag | chip_select_assert_flag, 1'b0);
    end
    stop_test();
  end
  initial begin
    #100000;
    n_mismatch++;
    stop_test();
  end
endmodule // tb_top
